// file: dv/hdcw_frame_properties.sv
// Purpose: Port-level checks for the control-word frame master
// Assumes: Bench uses a divider of 4 and ce held high
// Notes: Bound to every hdcw_frame instance
`timescale 1ns/1ps
`default_nettype none
module hdcw_frame_properties
  import hdcw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic port_enable,
  input wire logic continuous,
  input wire hdcw_pkg::hdcw_tx_type tx_in,
  input wire logic tx_ready,
  input wire hdcw_pkg::hdcw_rx_type rx_out,
  input wire hdcw_pkg::hdcw_pins_type pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic sclk_q;
  logic [4:0] rise_q;
  // Serial clock rises since select fell or since the last word
  always_ff @(posedge clk) begin
    sclk_q <= pins.sclk;
    rise_q <= (reset || pins.cs_n || rx_out.valid) ? CNT_ZERO : rise_q + 5'(pins.sclk & ~sclk_q);
  end
  property p_idle_clk; pins.cs_n |-> !pins.sclk && !pins.so; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("idle clock or data not low");
  property p_reset; disable iff (1'b0) reset |=> pins.cs_n && !tx_ready && !rx_out.valid; endproperty
  a_reset: assert property (p_reset) else $error("reset does not idle the pins");
  property p_start; $fell(pins.cs_n) |-> $past(port_enable) && $past(tx_in.valid); endproperty
  a_start: assert property (p_start) else $error("frame started without request");
  property p_take; $fell(pins.cs_n) |-> tx_ready; endproperty
  a_take: assert property (p_take) else $error("byte not taken at select fall");
  property p_ready; tx_ready |-> !pins.cs_n; endproperty
  a_ready: assert property (p_ready) else $error("byte taken with select high");
  property p_so_hold; pins.sclk && $past(pins.sclk) |-> $stable(pins.so); endproperty
  a_so_hold: assert property (p_so_hold) else $error("data moved while clock high");
  property p_len; rx_out.valid |-> rise_q >= 5'd13 && rise_q <= 5'd25; endproperty
  a_len: assert property (p_len) else $error("frame length out of range");
  property p_end; $rose(pins.cs_n) |-> rx_out.valid || $past(rx_out.valid); endproperty
  a_end: assert property (p_end) else $error("select rose without word");
  property p_pulse; rx_out.valid |=> !rx_out.valid; endproperty
  a_pulse: assert property (p_pulse) else $error("word valid too long");
  property p_cont; continuous && rx_out.valid && !$past(pins.cs_n) |-> !pins.cs_n; endproperty
  a_cont: assert property (p_cont) else $error("select rose in continuous mode");
  c_start: cover property ($fell(pins.cs_n));
  c_word: cover property (rx_out.valid);
  c_cont: cover property (continuous && rx_out.valid && !pins.cs_n);
endmodule
bind hdcw_frame hdcw_frame_properties hdcw_frame_properties_inst(.clk(clk), .reset(reset),
  .port_enable(port_enable), .continuous(continuous), .tx_in(tx_in), .tx_ready(tx_ready),
  .rx_out(rx_out), .pins(pins));
`default_nettype wire

// file: dv/hdcw_slave_model.sv
// Purpose: Off-chip slave answering control words
// Assumes: Reply is {ctrl, ~ctrl} cut to its low nbits
// Notes: Released line toggles so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module hdcw_slave_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic so,
  input wire logic [4:0] nbits,
  output logic si,
  output logic [7:0] ctrl
);
  int n;
  logic [15:0] rep;
  initial begin
    si = 1'b0;
    n = 0;
    ctrl = 8'h00;
  end
  assign rep = {ctrl, ~ctrl};
  always @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      n <= 0;
    end else begin
      if (n < 8) ctrl <= {ctrl[6:0], so};
      n <= (n == 8 + nbits) ? 0 : n + 1;
    end
  end
  always @(negedge sclk or posedge cs_n) begin
    if (!cs_n && n >= 9 && n < 9 + nbits) si <= rep[nbits - 1 - (n - 9)];
    else si <= ~si;
  end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench for the control-word frame master
// Assumes: Divider 4, ce held high
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hdcw_pkg::*;
  logic clk, reset, ce, port_enable, continuous, slave_mode, slave_sclk, slave_cs_n, ssi, msi, csq;
  logic [3:0] data_size_m1;
  hdcw_tx_type tx_in;
  logic tx_ready;
  hdcw_rx_type rx_out, slave_rx_out;
  hdcw_pins_type pins;
  logic [7:0] seen;
  int err_total, total_checks, cs_rises;
  logic [15:0] rxq[$], srxq[$];
  hdcw_frame #(.DIV_HALF(4)) hdcw_frame_inst(.clk(clk), .reset(reset), .ce(ce), .port_enable(port_enable),
    .continuous(continuous), .data_size_m1(data_size_m1), .tx_in(tx_in), .tx_ready(tx_ready), .rx_out(rx_out),
    .pins(pins), .serial_in(slave_mode ? ssi : msi), .slave_mode(slave_mode), .slave_sclk(slave_sclk),
    .slave_cs_n(slave_cs_n), .slave_rx_out(slave_rx_out));
  hdcw_slave_model hdcw_slave_model_inst(.sclk(pins.sclk), .cs_n(pins.cs_n), .so(pins.so),
    .nbits(5'(data_size_m1) + 5'h01), .si(msi), .ctrl(seen));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    csq <= pins.cs_n;
    if (pins.cs_n === 1'b1 && csq === 1'b0) cs_rises++;
    if (rx_out.valid === 1'b1) rxq.push_back(rx_out.data);
    if (slave_rx_out.valid === 1'b1) srxq.push_back(slave_rx_out.data);
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task send(input logic [7:0] c);
    int i;
    tx_in = {1'b1, c};
    cyc(1);
    i = 1;
    while (tx_ready !== 1'b1 && i < 2000) begin
      cyc(1);
      i++;
    end
    tx_in.valid = 1'b0;
    chk("taken", 16'h1, 16'(i < 2000));
  endtask
  task wait_rx(input int k);
    int i;
    i = 0;
    while (rxq.size() < k && i < 3000) begin
      cyc(1);
      i++;
    end
    chk("words", 16'(k), 16'(rxq.size()));
  endtask
  task t_idle;
    tx_in = {1'b1, 8'h5a};
    cyc(40);
    chk("idle pins", 16'h2, {13'h0, pins});
    tx_in.valid = 1'b0;
    $display("idle test done");
  endtask
  task t_single(input logic [7:0] c, input logic [4:0] n);
    logic [16:0] m;
    m = (17'h1 << n) - 17'h1;
    port_enable = 1'b1;
    data_size_m1 = 4'(n - 5'h1);
    rxq.delete();
    send(c);
    wait_rx(1);
    chk("ctrl", {8'h0, c}, {8'h0, seen});
    chk("reply", {c, ~c} & m[15:0], rxq[0]);
    cyc(10);
    chk("select", 16'h1, {15'h0, pins.cs_n});
    $display("single test done");
  endtask
  task t_cont;
    int r0;
    r0 = cs_rises;
    data_size_m1 = 4'h7;
    continuous = 1'b1;
    rxq.delete();
    send(8'h3c);
    send(8'hc3);
    continuous = 1'b0;
    wait_rx(2);
    cyc(10);
    chk("first", 16'h00c3, rxq[0]);
    chk("second", 16'h003c, rxq[1]);
    chk("select rises", 16'h1, 16'(cs_rises - r0));
    $display("continuous test done");
  endtask
  task t_slave(input logic [7:0] b);
    slave_mode = 1'b1;
    slave_cs_n = 1'b0;
    cyc(16);
    for (int i = 7; i >= 0; i--) begin
      ssi = b[i];
      cyc(4);
      slave_sclk = 1'b1;
      cyc(4);
      slave_sclk = 1'b0;
    end
    cyc(8);
    slave_cs_n = 1'b1;
    chk("slave word", {8'h0, b}, {8'h0, srxq[0][7:0]});
    $display("slave test done");
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    port_enable = 1'b0;
    continuous = 1'b0;
    slave_mode = 1'b0;
    slave_sclk = 1'b0;
    slave_cs_n = 1'b1;
    ssi = 1'b0;
    data_size_m1 = 4'h3;
    tx_in = '0;
    cyc(5);
    reset = 1'b0;
    t_idle();
    t_single(8'ha5, 5'd4);
    t_single(8'h96, 5'd16);
    t_cont();
    t_slave(8'hb4);
    end_sim();
  end
  initial begin
    #1000000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire

// file: rtl/hdcw_frame.sv
// Purpose: Half-duplex control-word serial frame master with slave-mode sampling
// Assumes: Reply line and slave chip select come from outside and are synchronised here
// Notes: Serial clock is a divided system clock; one clock-enable freezes all state
//
// Overview of operation
// RULE1: Frame opens with eight control bits, receiver blind.
// RULE2: Slave replies after one serial clock wait.
// RULE3: Reply is four to sixteen bits long.
// RULE4: Idle: clock low, select high, output low.
// RULE5: Frame starts when control byte queued, enabled.
// RULE6: Select fall loads byte, MSB to output.
// RULE7: Select stays low; input undriven during control.
// RULE8: Slave samples rising, drives reply on falling.
// RULE9: Reply bits captured on serial clock rise.
// RULE10: Single: select rises one period, commits word.
// RULE11: Slave may release line after last bit.
// RULE12: Continuous: select low, next byte follows immediately.
// RULE13: Continuous: word committed on following falling edge.
// RULE14: Slave mode samples first rise after select.
// RULE15: External master sets select two periods early.
// RULE16: Reply length comes from size setting.

`timescale 1ns/1ps
`default_nettype none

module hdcw_frame #(
  parameter int unsigned DIV_HALF = hdcw_pkg::DIV_HALF_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic port_enable,
  input wire logic continuous,
  input wire logic [3:0] data_size_m1,
  input wire hdcw_pkg::hdcw_tx_type tx_in,
  output logic tx_ready,
  output hdcw_pkg::hdcw_rx_type rx_out,
  output hdcw_pkg::hdcw_pins_type pins,
  input wire logic serial_in,
  input wire logic slave_mode,
  input wire logic slave_sclk,
  input wire logic slave_cs_n,
  output hdcw_pkg::hdcw_rx_type slave_rx_out
);
  import hdcw_pkg::*;

  // ********************
  // Input synchronisers
  // ********************
  logic [1:0] sin_q, ssck_q, scs_q;
  logic ssck_prev_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sin_q <= 2'h0;
      ssck_q <= 2'h0;
      scs_q <= 2'h3;
      ssck_prev_q <= 1'b0;
    end else if (ce) begin
      sin_q <= {sin_q[0], serial_in};
      ssck_q <= {ssck_q[0], slave_sclk};
      scs_q <= {scs_q[0], slave_cs_n};
      ssck_prev_q <= ssck_q[1];
    end
  end

  // ********************
  // Serial clock divider
  // ********************
  localparam int unsigned DW = $clog2(DIV_HALF + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV_HALF - 1);
  hdcw_state_type state_q, state_d;
  logic [DW-1:0] div_q;
  logic sclk_q;
  wire running = (state_q != ST_IDLE);
  wire half_tick = running && (div_q == DIV_LAST);
  wire rise_tick = half_tick && !sclk_q;
  wire fall_tick = half_tick && sclk_q;

  always_ff @(posedge clk) begin
    if (reset || !running) begin
      div_q <= '0;
    end else if (ce) begin
      div_q <= half_tick ? '0 : div_q + DW'(1);
    end
  end

  // ********************
  // Frame sequencer
  // ********************
  logic [4:0] bit_q, bit_d;
  logic [7:0] tsr_q;
  logic [15:0] rsr_q;
  logic [3:0] size_q;
  logic cs_n_q, so_q, rx_pend_q;
  hdcw_rx_type rx_q;
  wire [4:0] reply_last = {1'b0, size_q};
  wire take_byte = port_enable && tx_in.valid; // RULE5
  wire reply_done = (state_q == ST_DATA) && rise_tick && (bit_q == reply_last);

  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    unique case (state_q)
      ST_IDLE: if (take_byte) state_d = ST_LEAD; // RULE5
      ST_LEAD: if (half_tick) begin
        state_d = ST_CTRL;
        bit_d = CNT_ZERO;
      end
      ST_CTRL: if (fall_tick) begin // RULE1
        if (bit_q == CTRL_LAST) begin
          state_d = ST_WAIT;
          bit_d = CNT_ZERO;
        end else begin
          bit_d = bit_q + CNT_ONE;
        end
      end
      ST_WAIT: if (fall_tick) begin // RULE2
        state_d = ST_DATA;
        bit_d = CNT_ZERO;
      end
      ST_DATA: if (rise_tick) begin // RULE9
        if (bit_q == reply_last) begin // RULE16
          state_d = ST_TAIL;
        end else begin
          bit_d = bit_q + CNT_ONE;
        end
      end
      ST_TAIL: if (fall_tick) begin
        if (continuous && take_byte) begin // RULE12
          state_d = ST_CTRL;
          bit_d = CNT_ZERO;
        end else begin
          bit_d = WAIT_CNT;
        end
      end else if (rise_tick && (bit_q == WAIT_CNT)) begin
        // One full period after the last capture: close the frame
        state_d = ST_IDLE; // RULE10
        bit_d = CNT_ZERO;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Load paths for the transmit shifter and commit strobes for the reply word
  wire load_first = (state_q == ST_IDLE) && take_byte;
  wire load_next = (state_q == ST_TAIL) && fall_tick && continuous && take_byte;
  wire ctrl_shift = (state_q == ST_CTRL) && fall_tick && (bit_q != CTRL_LAST);
  wire ctrl_end = (state_q == ST_CTRL) && fall_tick && (bit_q == CTRL_LAST);
  wire commit_cont = load_next && rx_pend_q; // RULE13
  wire commit_single = (state_q == ST_TAIL) && rise_tick && (bit_q == WAIT_CNT); // RULE10

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bit_q <= CNT_ZERO;
      sclk_q <= 1'b0; // RULE4
      cs_n_q <= 1'b1; // RULE4
      so_q <= 1'b0; // RULE4
      tsr_q <= 8'h00;
      rsr_q <= 16'h0000;
      size_q <= SIZE_RESET;
      rx_pend_q <= 1'b0;
      rx_q <= '0;
      tx_ready <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      bit_q <= bit_d;
      tx_ready <= load_first || load_next;
      rx_q.valid <= 1'b0;
      // Frame end keeps the clock low so the slave sees no extra rising edge
      sclk_q <= commit_single ? 1'b0 : (half_tick ? !sclk_q : (running ? sclk_q : 1'b0)); // RULE4
      if (load_first) begin
        cs_n_q <= 1'b0; // RULE6
        tsr_q <= tx_in.ctrl; // RULE6
        so_q <= tx_in.ctrl[7]; // RULE6
        size_q <= (data_size_m1 < 4'(REPLY_MIN - 1)) ? 4'(REPLY_MIN - 1) : data_size_m1; // RULE3
        rsr_q <= 16'h0000;
      end else if (load_next) begin
        tsr_q <= tx_in.ctrl; // RULE12
        so_q <= tx_in.ctrl[7]; // RULE12
        size_q <= (data_size_m1 < 4'(REPLY_MIN - 1)) ? 4'(REPLY_MIN - 1) : data_size_m1;
        rsr_q <= 16'h0000;
      end else if (ctrl_shift) begin
        tsr_q <= {tsr_q[6:0], 1'b0};
        so_q <= tsr_q[6];
      end else if (ctrl_end) begin
        so_q <= 1'b0;
      end
      if (state_q == ST_DATA && rise_tick) begin
        rsr_q <= {rsr_q[14:0], sin_q[1]}; // RULE9
      end
      if (reply_done) rx_pend_q <= 1'b1;
      if (commit_cont || commit_single) begin
        rx_q.valid <= rx_pend_q; // RULE13
        rx_q.data <= rsr_q;
        rx_pend_q <= 1'b0;
      end
      if (commit_single) cs_n_q <= 1'b1; // RULE10 RULE7
    end
  end

  // ********************
  // Slave-mode receive
  // ********************
  logic [15:0] srs_q;
  logic [4:0] scnt_q;
  hdcw_rx_type srx_q;
  wire s_rise = slave_mode && !scs_q[1] && ssck_q[1] && !ssck_prev_q; // RULE14 RULE15
  always_ff @(posedge clk) begin
    if (reset) begin
      srs_q <= 16'h0000;
      scnt_q <= CNT_ZERO;
      srx_q <= '0;
    end else if (ce) begin
      srx_q.valid <= 1'b0;
      if (scs_q[1]) begin
        scnt_q <= CNT_ZERO;
      end else if (s_rise) begin
        srs_q <= {srs_q[14:0], sin_q[1]}; // RULE14
        if (scnt_q == CTRL_LAST) begin
          srx_q.valid <= 1'b1;
          srx_q.data <= {8'h00, srs_q[6:0], sin_q[1]};
          scnt_q <= CNT_ZERO;
        end else begin
          scnt_q <= scnt_q + CNT_ONE;
        end
      end
    end
  end

  assign pins = '{sclk: sclk_q, cs_n: cs_n_q, so: so_q};
  assign rx_out = rx_q;
  assign slave_rx_out = srx_q;

endmodule

`default_nettype wire

// file: rtl/hdcw_pkg.sv
// Purpose: Shared constants and carriers for the half-duplex control-word serial frame block
// Assumes: 20 MHz system clock
// Notes: Link clock rate is set by a divider count

package hdcw_pkg;

  localparam int unsigned CTRL_BITS = 8;
  localparam int unsigned REPLY_MIN = 4;
  localparam int unsigned REPLY_MAX = 16;
  localparam int unsigned WAIT_BITS = 1;
  localparam int unsigned DIV_HALF_DEFAULT = 4;
  localparam logic [3:0] SIZE_RESET = 4'h7;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] WAIT_CNT = 5'h01;
  localparam logic [4:0] CTRL_LAST = 5'h07;

  // Transmit side request: a control byte offered to the port
  typedef struct packed {
    logic valid;
    logic [7:0] ctrl;
  } hdcw_tx_type;

  // Receive side result: one committed reply word
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } hdcw_rx_type;

  // Pins driven by the master side
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic so;
  } hdcw_pins_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_LEAD = 6'b000010,
    ST_CTRL = 6'b000100,
    ST_WAIT = 6'b001000,
    ST_DATA = 6'b010000,
    ST_TAIL = 6'b100000
  } hdcw_state_type;

endpackage
